// *** tb/wheel_speed_protocol_framer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module wheel_speed_protocol_framer_test;
    localparam int unsigned DLY = 24;
    logic mclk = 1'b0, rst_n = 1'b0, zc = 1'b0, hy = 1'b0, nm = 1'b0, lo = 1'b0;
    logic dv = 1'b0, bl = 1'b0, dr = 1'b0, dg = 1'b0, ls, busy, hi, bad_cell;
    logic [2:0] cl = 3'h0;
    logic [1:0] lvl;
    logic [8:0] frm, word, r, prev;
    logic [3:0] cnt;
    int bad_count = 0;
    int num_checks = 0;
    // Rows: {normal, diag, dir, below, valid, class[2:0], too_low}.
    logic [8:0] rows [9] = '{9'h1b1, 9'h172, 9'h1d5, 9'h126, 9'h189, 9'h14a, 9'h1fd,
                             9'h0ff, 9'h13e};
    wsf_framer #(.BIT_CYC(16), .PULSE_CYC(40), .STOP_CYC(2000), .NO_CROSSING_CYC(5000),
        .HYST_CYC(3000)) i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .zero_cross_i(zc),
        .hyst_passed_i(hy), .normal_mode_i(nm), .amplitude_too_low_flag_i(lo),
        .amplitude_class_code_i(cl), .direction_valid_flag_i(dv), .below_dir_limit_i(bl),
        .rotation_direction_bit_i(dr), .diag_input_state_i(dg), .current_level_o(lvl),
        .low_speed_o(ls), .frame_busy_o(busy), .frame_o(frm));
    wsf_ctrl_unit i_cu (.mclk_i(mclk), .level_i(lvl), .word_o(word),
        .count_o(cnt), .bad_cell_o(bad_cell));
    initial forever #4 mclk = ~mclk;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic xing();
        @(posedge mclk);
        #1 zc = 1'b1;
        hy = 1'b1;
        @(posedge mclk);
        #1 zc = 1'b0;
        hy = 1'b0;
    endtask
    // Waits out one frame, noting whether a high-level pulse went by.
    task automatic waitf();
        logic seen;
        seen = 1'b0;
        hi = 1'b0;
        for (int n = 0; n < 2500 && !(seen && busy === 1'b0); n++) begin
            @(posedge mclk);
            #1 seen = seen | (busy === 1'b1);
            hi = hi | (lvl === 2'h2);
        end
        chk({8'h00, seen}, 9'h001);
    endtask
    function automatic logic [8:0] ex(input logic [8:0] v, input logic s);
        logic [7:0] b;
        b = {v[3:1], v[6], v[4] & v[5] & v[8] & !s, v[7], !v[8] | s, v[0]};
        return {^b, b};
    endfunction
    initial begin
        #(8 * 30000);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk(frm, 9'h102);
        prev = rows[0];
        for (int i = 0; i < 9; i++) begin
            r = rows[i];
            nm = r[8];
            dg = r[7];
            dr = r[6];
            bl = r[5];
            dv = r[4];
            cl = r[3:1];
            lo = r[0];
            if (!r[8]) r[3:0] = prev[3:0];
            xing();
            waitf();
            chk(word, ex(r, 1'b0));
            chk({5'h00, cnt}, 9'h009);
            chk(frm, ex(r, 1'b0));
            prev = r;
        end
        waitf();
        chk({8'h00, hi}, 9'h000);
        chk(word, ex(r, 1'b0));
        waitf();
        chk({8'h00, ls}, 9'h001);
        chk(word, ex(r, 1'b0) ^ 9'h102);
        xing();
        repeat (100) @(posedge mclk);
        xing();
        repeat (DLY) @(posedge mclk);
        #1 chk({7'h00, lvl}, 9'h000);
        chk({5'h00, cnt}, 9'h002);
        @(posedge mclk);
        #1 chk({7'h00, lvl}, 9'h002);
        waitf();
        chk({8'h00, bad_cell}, 9'h000);
        chk(word, ex(r, 1'b1));
        wrap_up();
    end
endmodule
`default_nettype wire

// *** tb/wsf_ctrl_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Control unit model: decodes Manchester cells after each long pulse.
// The default HALF matches half the bit cell that the bench gives the framer.
// ----------------------------------------------------------------------------
module wsf_ctrl_unit #(
    parameter int unsigned HALF = 8
) (
    input wire logic mclk_i,
    input wire logic [1:0] level_i,
    output logic [8:0] word_o,
    output logic [3:0] count_o,
    output logic bad_cell_o
);
    int run_q = 0;
    int pos_q = 0;
    logic [1:0] first_q = 2'h0;
    initial bad_cell_o = 1'b0;
    // Mid runs inside a frame never exceed one cell, so a longer run is a pulse.
    always @(posedge mclk_i) begin
        run_q <= (level_i != 2'h0) ? run_q + 1 : 0;
        if (level_i == 2'h2) begin
            pos_q <= 0;
        end else if (level_i == 2'h0 && run_q > 2 * HALF) begin
            pos_q <= 1;
            count_o <= 4'h0;
            word_o <= 9'h000;
        end else if (pos_q != 0) begin
            pos_q <= pos_q + 1;
            if (pos_q % (2 * HALF) == HALF + HALF / 2) begin
                first_q <= level_i;
            end
            if (pos_q > 2 * HALF && pos_q % (2 * HALF) == HALF / 2) begin
                if (level_i == 2'h0 && first_q == 2'h0) begin
                    // Both halves low: the frame was cut short, so stop decoding.
                    pos_q <= 0;
                end else begin
                    if (level_i == first_q) begin
                        bad_cell_o <= 1'b1;
                    end
                    word_o[count_o] <= (level_i == 2'h1);
                    count_o <= count_o + 4'h1;
                    if (count_o == 4'h8) begin
                        pos_q <= 0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/wsf_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
module wsf_framer #(
    parameter int unsigned BIT_CYC = wsf_pkg::BIT_CYC,
    parameter int unsigned PULSE_CYC = wsf_pkg::PULSE_CYC,
    parameter int unsigned STOP_CYC = wsf_pkg::STOP_CYC,
    parameter int unsigned NO_CROSSING_CYC = wsf_pkg::NO_CROSSING_CYC,
    parameter int unsigned HYST_CYC = wsf_pkg::HYST_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic zero_cross_i,
    input wire logic hyst_passed_i,
    input wire logic normal_mode_i,
    input wire logic amplitude_too_low_flag_i,
    input wire logic [2:0] amplitude_class_code_i,
    input wire logic direction_valid_flag_i,
    input wire logic below_dir_limit_i,
    input wire logic rotation_direction_bit_i,
    input wire logic diag_input_state_i,
    output logic [1:0] current_level_o,
    output logic low_speed_o,
    output logic frame_busy_o,
    output logic [8:0] frame_o
);
    // ------------------------------------------------------------------------
    // Derived timing.
    // ------------------------------------------------------------------------
    // Half a bit cell; also the least gap ahead of a speed pulse.
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    // The fixed crossing-to-pulse delay covers one whole bit plus half a bit,
    // so a bit still running at a crossing always ends with the gap to spare.
    localparam int unsigned DELAY_CYC = BIT_CYC + HALF_CYC;

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    wsf_pkg::wsf_state_type state_q; // Transmitter state.
    logic [wsf_pkg::CNT_W-1:0] cnt_q; // Cycles left in the current phase.
    logic [3:0] bit_idx_q; // Index of the bit being sent.
    logic artificial_q; // The running frame is a repeat.
    logic abort_q; // A crossing asked to cut the frame short.
    logic delay_busy_q; // A crossing waits for its speed pulse.
    logic [wsf_pkg::CNT_W-1:0] delay_cnt_q; // Cycles left of the delay.
    logic repeat_pend_q; // Stop interval elapsed, repeat wanted.
    logic low_speed_q; // Low-speed mode entered.
    logic normal_seen_q; // Previous value of the normal-mode input.
    logic [7:0] frame_q; // Data bits 7..0 of the frame.
    wsf_pkg::wsf_level_type level_q; // Registered output current level.
    wsf_pkg::wsf_level_type cell_level; // Level of the current bit cell.
    logic delay_ready; // Delay done; a real pulse may start.
    logic mode_bit; // Live value of the mode bit.
    logic tx_bit; // Value of the bit being sent.
    logic stop_expired; // Stop interval elapsed.
    logic nozc_expired; // No crossing for the low-speed limit.
    logic hyst_expired; // Hysteresis not passed in time.
    logic phase_end; // Current phase ends this cycle.

    assign delay_ready = delay_busy_q && (delay_cnt_q == '0);
    assign mode_bit = !normal_mode_i || low_speed_q;
    // Parity bit is derived, never stored, so it cannot go stale.
    assign tx_bit = (bit_idx_q == wsf_pkg::LAST_BIT_IDX) ? ^frame_q : frame_q[bit_idx_q[2:0]];
    assign phase_end = (cnt_q == '0);

    // ------------------------------------------------------------------------
    // Timers.
    // ------------------------------------------------------------------------
    // The stop interval restarts at every crossing and reloads at every expiry.
    wsf_interval_timer #(
        .PERIOD(STOP_CYC)
    ) u_stop_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .restart_i(zero_cross_i),
        .expired_o(stop_expired)
    );

    // Watches for the absence of crossings.
    wsf_interval_timer #(
        .PERIOD(NO_CROSSING_CYC)
    ) u_nozc_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .restart_i(zero_cross_i),
        .expired_o(nozc_expired)
    );

    // Watches for the hysteresis level not being passed.
    wsf_interval_timer #(
        .PERIOD(HYST_CYC)
    ) u_hyst_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .restart_i(hyst_passed_i),
        .expired_o(hyst_expired)
    );

    // Bit cell shaping.
    wsf_manchester_cell u_cell (
        .bit_i(tx_bit),
        .second_half_i(state_q == wsf_pkg::ST_SECOND),
        .level_o(cell_level)
    );

    // ------------------------------------------------------------------------
    // Crossing-to-pulse delay.
    // ------------------------------------------------------------------------
    // A crossing arriving while one is already delayed is dropped; at the
    // specified wheel rates crossings are far more than one delay apart.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            delay_busy_q <= 1'b0;
            delay_cnt_q <= '0;
        end else if (zero_cross_i && !delay_busy_q) begin
            delay_busy_q <= 1'b1;
            delay_cnt_q <= wsf_pkg::CNT_W'(DELAY_CYC - 1);
        end else if (delay_ready && state_q == wsf_pkg::ST_IDLE) begin
            delay_busy_q <= 1'b0;
        end else if (delay_busy_q && !delay_ready) begin
            delay_cnt_q <= delay_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Repeat request, abort request and low-speed flag.
    // ------------------------------------------------------------------------
    // Each flag is set by an event and cleared by its consumer, low speed by a return to normal mode; set wins.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            repeat_pend_q <= 1'b0;
        end else if (stop_expired) begin
            repeat_pend_q <= 1'b1;
        end else if (zero_cross_i || (state_q == wsf_pkg::ST_IDLE && !delay_ready)) begin
            repeat_pend_q <= 1'b0;
        end
    end

    // A crossing during a frame cuts it at the next bit boundary.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            abort_q <= 1'b0;
        end else if (zero_cross_i && state_q != wsf_pkg::ST_IDLE) begin
            abort_q <= 1'b1;
        end else if (state_q == wsf_pkg::ST_IDLE) begin
            abort_q <= 1'b0;
        end
    end

    // Low-speed mode is left once the mode logic reports normal mode again.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            low_speed_q <= 1'b0;
            normal_seen_q <= 1'b0;
        end else begin
            normal_seen_q <= normal_mode_i;
            if (nozc_expired || hyst_expired) begin
                low_speed_q <= 1'b1;
            end else if (normal_mode_i && !normal_seen_q) begin
                low_speed_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Transmitter sequence.
    // ------------------------------------------------------------------------
    // Pulse, half-bit gap, then up to nine Manchester cells in ascending order.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= wsf_pkg::ST_IDLE;
            cnt_q <= '0;
            bit_idx_q <= 4'h0;
            artificial_q <= 1'b0;
        end else begin
            unique case (state_q)
                wsf_pkg::ST_IDLE: begin
                    // A real pulse outranks a repeat that falls due together.
                    if (delay_ready) begin
                        state_q <= wsf_pkg::ST_PULSE;
                        cnt_q <= wsf_pkg::CNT_W'(PULSE_CYC - 1);
                        artificial_q <= 1'b0;
                    end else if (repeat_pend_q) begin
                        state_q <= wsf_pkg::ST_PULSE;
                        cnt_q <= wsf_pkg::CNT_W'(PULSE_CYC - 1);
                        artificial_q <= 1'b1;
                    end
                end
                wsf_pkg::ST_PULSE: begin
                    if (phase_end) begin
                        state_q <= wsf_pkg::ST_GAP;
                        cnt_q <= wsf_pkg::CNT_W'(HALF_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                wsf_pkg::ST_GAP: begin
                    if (phase_end && (abort_q || zero_cross_i)) begin
                        state_q <= wsf_pkg::ST_IDLE;
                    end else if (phase_end) begin
                        state_q <= wsf_pkg::ST_FIRST;
                        cnt_q <= wsf_pkg::CNT_W'(HALF_CYC - 1);
                        bit_idx_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                wsf_pkg::ST_FIRST: begin
                    if (phase_end) begin
                        state_q <= wsf_pkg::ST_SECOND;
                        cnt_q <= wsf_pkg::CNT_W'(HALF_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                wsf_pkg::ST_SECOND: begin
                    // A started bit always completes before a cut.
                    if (phase_end && (abort_q || zero_cross_i)) begin
                        state_q <= wsf_pkg::ST_IDLE;
                    end else if (phase_end && bit_idx_q == wsf_pkg::LAST_BIT_IDX) begin
                        state_q <= wsf_pkg::ST_IDLE;
                    end else if (phase_end) begin
                        state_q <= wsf_pkg::ST_FIRST;
                        cnt_q <= wsf_pkg::CNT_W'(HALF_CYC - 1);
                        bit_idx_q <= bit_idx_q + 4'h1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= wsf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Frame content.
    // ------------------------------------------------------------------------
    // Content is fixed by the end of the pulse so a frame never changes mid-flight.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            frame_q <= wsf_pkg::FRAME_RESET;
        end else if (state_q == wsf_pkg::ST_IDLE && delay_ready) begin
            frame_q[wsf_pkg::BIT_MODE] <= mode_bit;
            frame_q[wsf_pkg::BIT_DIR_VALID] <= direction_valid_flag_i && normal_mode_i
                && !low_speed_q && below_dir_limit_i;
            frame_q[wsf_pkg::BIT_DIR] <= rotation_direction_bit_i;
            if (normal_mode_i) begin
                frame_q[wsf_pkg::BIT_AMP_LOW] <= amplitude_too_low_flag_i;
                frame_q[7:5] <= amplitude_class_code_i;
            end
        end else if (state_q == wsf_pkg::ST_IDLE && repeat_pend_q) begin
            // A repeat resends the old frame but shows the current mode.
            frame_q[wsf_pkg::BIT_MODE] <= mode_bit;
        end else if (state_q == wsf_pkg::ST_PULSE && phase_end && !artificial_q) begin
            // The diagnostic input is only measured under the high current.
            frame_q[wsf_pkg::BIT_DIAG] <= diag_input_state_i;
        end
    end

    // ------------------------------------------------------------------------
    // Output level.
    // ------------------------------------------------------------------------
    // Registered so the pin never glitches; it lags the state by one cycle.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            level_q <= wsf_pkg::LVL_LOW;
        end else begin
            unique case (state_q)
                wsf_pkg::ST_PULSE: begin
                    level_q <= artificial_q ? wsf_pkg::LVL_MID : wsf_pkg::LVL_HIGH;
                end
                wsf_pkg::ST_FIRST, wsf_pkg::ST_SECOND: begin
                    level_q <= cell_level;
                end
                default: begin
                    level_q <= wsf_pkg::LVL_LOW;
                end
            endcase
        end
    end

    // Status outputs, all from flip-flops.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            frame_busy_o <= 1'b0;
            frame_o <= {1'b1, wsf_pkg::FRAME_RESET};
        end else begin
            frame_busy_o <= (state_q != wsf_pkg::ST_IDLE);
            frame_o <= {^frame_q, frame_q};
        end
    end

    assign current_level_o = level_q;
    assign low_speed_o = low_speed_q;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_bit_end;
        state_q == wsf_pkg::ST_SECOND && phase_end;
    endsequence
    sequence s_real_start;
        state_q == wsf_pkg::ST_IDLE && delay_ready;
    endsequence

    property p_real_high;
        state_q == wsf_pkg::ST_PULSE && !artificial_q |=> level_q == wsf_pkg::LVL_HIGH;
    endproperty
    a_real_high: assert property (p_real_high) else $error("real pulse not high");

    property p_art_mid;
        state_q == wsf_pkg::ST_PULSE && artificial_q |=> level_q == wsf_pkg::LVL_MID;
    endproperty
    a_art_mid: assert property (p_art_mid) else $error("artificial pulse not mid");

    property p_gap_low;
        state_q == wsf_pkg::ST_PULSE && phase_end |=> state_q == wsf_pkg::ST_GAP ##1
            level_q == wsf_pkg::LVL_LOW;
    endproperty
    a_gap_low: assert property (p_gap_low) else $error("no low gap after pulse");

    property p_manchester;
        state_q == wsf_pkg::ST_FIRST && phase_end |=> (level_q == (tx_bit ? wsf_pkg::LVL_LOW
            : wsf_pkg::LVL_MID)) ##1 (level_q == (tx_bit ? wsf_pkg::LVL_MID : wsf_pkg::LVL_LOW));
    endproperty
    a_manchester: assert property (p_manchester) else $error("bad mid-cell edge");

    property p_ascending;
        s_bit_end ##0 (!abort_q && !zero_cross_i && bit_idx_q != wsf_pkg::LAST_BIT_IDX)
            |=> state_q == wsf_pkg::ST_FIRST && bit_idx_q == $past(bit_idx_q) + 4'h1;
    endproperty
    a_ascending: assert property (p_ascending) else $error("bits out of order");

    property p_nine_bits;
        s_bit_end ##0 bit_idx_q == wsf_pkg::LAST_BIT_IDX |=> state_q == wsf_pkg::ST_IDLE;
    endproperty
    a_nine_bits: assert property (p_nine_bits) else $error("frame not nine bits");

    property p_abort;
        s_bit_end ##0 abort_q |=> state_q == wsf_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("frame not cut after bit");

    property p_parity;
        state_q == wsf_pkg::ST_SECOND && bit_idx_q == wsf_pkg::LAST_BIT_IDX |=>
            level_q == ((^frame_q) ? wsf_pkg::LVL_MID : wsf_pkg::LVL_LOW);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit wrong");

    property p_mode_load;
        s_real_start |=> frame_q[wsf_pkg::BIT_MODE] == $past(mode_bit);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode bit not loaded");

    property p_diag_hold;
        !(state_q == wsf_pkg::ST_PULSE && !artificial_q) |=>
            frame_q[wsf_pkg::BIT_DIAG] == $past(frame_q[wsf_pkg::BIT_DIAG]);
    endproperty
    a_diag_hold: assert property (p_diag_hold) else $error("diag bit moved");

    property p_low_speed;
        nozc_expired || hyst_expired |=> low_speed_q;
    endproperty
    a_low_speed: assert property (p_low_speed) else $error("low-speed not entered");
endmodule
`default_nettype wire

// *** verilog/wsf_interval_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Retriggerable interval timer: pulses once per PERIOD cycles without restart.
// ----------------------------------------------------------------------------
module wsf_interval_timer #(
    parameter int unsigned PERIOD = 16
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    output logic expired_o
);
    // Cycles left until the next expiry.
    logic [31:0] left_q;

    // Count down; reload on restart or at expiry so the pulse repeats.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            // Start a full period at reset, so no false expiry follows it.
            left_q <= 32'(PERIOD - 1);
            expired_o <= 1'b0;
        end else if (restart_i) begin
            left_q <= 32'(PERIOD - 1);
            expired_o <= 1'b0;
        end else if (left_q == 32'h0) begin
            // Reloading here keeps repeats exactly one period apart.
            left_q <= 32'(PERIOD - 1);
            expired_o <= 1'b1;
        end else begin
            left_q <= left_q - 32'h1;
            expired_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verilog/wsf_manchester_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Current level of one Manchester bit cell half at the intermediate level.
// ----------------------------------------------------------------------------
module wsf_manchester_cell (
    input wire logic bit_i,
    input wire logic second_half_i,
    output wsf_pkg::wsf_level_type level_o
);
    // A one rises at mid-cell, a zero falls; so the first half is the inverse.
    always_comb begin
        if (bit_i ^ second_half_i) begin
            level_o = wsf_pkg::LVL_LOW;
        end else begin
            level_o = wsf_pkg::LVL_MID;
        end
    end
endmodule
`default_nettype wire

// *** verilog/wsf_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants of the wheel speed status frame framer.
// ----------------------------------------------------------------------------
package wsf_pkg;
    // Clock period of the internal oscillator clock in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Bit period of one frame bit cell in nanoseconds; plain default value.
    localparam int unsigned BIT_PERIOD_NS = 50000;
    // Width of the high-level speed pulse in nanoseconds; plain default value.
    localparam int unsigned PULSE_WIDTH_NS = 25000;
    // Stop interval after which the previous frame is repeated.
    localparam int unsigned STOP_INTERVAL_MS = 150;
    // Longest wait for a zero-crossing before low-speed mode.
    localparam int unsigned NO_CROSSING_MS = 1000;
    // Longest wait for the hysteresis level to be passed.
    localparam int unsigned HYST_TIMEOUT_MS = 250;
    // Derived cycle counts; all periods are exact multiples of the clock period.
    localparam int unsigned BIT_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CYC = PULSE_WIDTH_NS / CLK_PERIOD_NS;
    localparam int unsigned STOP_CYC = STOP_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned NO_CROSSING_CYC = NO_CROSSING_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned HYST_CYC = HYST_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    // Width of the cycle counters.
    localparam int unsigned CNT_W = 32;
    // Frame layout.
    localparam int unsigned FRAME_BITS = 9;
    localparam int unsigned BIT_AMP_LOW = 0;
    localparam int unsigned BIT_MODE = 1;
    localparam int unsigned BIT_DIAG = 2;
    localparam int unsigned BIT_DIR_VALID = 3;
    localparam int unsigned BIT_DIR = 4;
    localparam int unsigned BIT_CLASS_LSB = 5;
    localparam logic [3:0] LAST_BIT_IDX = 4'h8;
    // Power-up value of data bits 7..0: only the mode bit is set.
    localparam logic [7:0] FRAME_RESET = 8'h02;
    // Output current levels.
    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_MID = 2'h1,
        LVL_HIGH = 2'h2
    } wsf_level_type;
    // Transmitter states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PULSE = 3'h1,
        ST_GAP = 3'h2,
        ST_FIRST = 3'h3,
        ST_SECOND = 3'h4
    } wsf_state_type;
endpackage
`default_nettype wire
